// *** spl_params.svh ***
// Constants for the serial-to-parallel latched shifter.
// Assumes it is included by bare name wherever a figure is needed.
`ifndef SPL_PARAMS_SVH
`define SPL_PARAMS_SVH

`define SPL_STAGES       8
`define SPL_LAST_STAGE   7
`define SPL_PIN_COUNT    5
`define SPL_PIN_DATA     0
`define SPL_PIN_SHIFT    1
`define SPL_PIN_LATCH    2
`define SPL_PIN_CLEAR_N  3
`define SPL_PIN_OE_N     4
`define SPL_PIN_RST_VAL  5'h18
`define SPL_BYTE_ZERO    8'h00
`define SPL_BYTE_ONES    8'hff

`endif

// *** spl_pkg.sv ***
// Types shared by the shifter core and its pin sampler.
// Assumes spl_params.svh is on the include path.
`include "spl_params.svh"

package spl_pkg;
    typedef logic [`SPL_STAGES-1:0]    spl_byte_t;
    typedef logic [`SPL_PIN_COUNT-1:0] spl_pins_t;
endpackage : spl_pkg

// *** spl_pin_if.sv ***
// Carries sampled pin levels and rising-edge pulses from sampler to core.
// Assumes both ends run on the same system clock.
`timescale 1ns/1ps

interface spl_pin_if;
    spl_pkg::spl_pins_t level;
    spl_pkg::spl_pins_t rise;
    modport sampler (output level, output rise);
    modport core    (input level, input rise);
endinterface : spl_pin_if

// *** spl_pin_sampler.sv ***
// Two-flop synchronisers and rising-edge finders for every input pin.
// Assumes all pins are asynchronous to clk and held at least two clk periods per level.
`timescale 1ns/1ps
`include "spl_params.svh"

module spl_pin_sampler (
    // Clock and reset
    input  wire logic               clk,
    input  wire logic               sys_rst,
    // Raw pins
    input  wire spl_pkg::spl_pins_t pins,
    // Sampled view
    spl_pin_if.sampler              pin_io
);
    spl_pkg::spl_pins_t meta;
    spl_pkg::spl_pins_t sync;
    spl_pkg::spl_pins_t prev;
    spl_pkg::spl_pins_t next_meta;
    spl_pkg::spl_pins_t next_sync;
    spl_pkg::spl_pins_t next_prev;

    // Idle level of each pin, held in a vector so that each chain picks its own bit.
    localparam spl_pkg::spl_pins_t pin_rst_val = `SPL_PIN_RST_VAL;

    genvar i;
    generate
        for (i = 0; i < `SPL_PIN_COUNT; i++) begin : g_pin
            // The first flop feeds only the second; edges are judged on the settled copies.
            always_comb begin
                next_meta[i] = sys_rst ? pin_rst_val[i] : pins[i];
                next_sync[i] = sys_rst ? pin_rst_val[i] : meta[i];
                next_prev[i] = sys_rst ? pin_rst_val[i] : sync[i];
            end
            always_ff @(posedge clk) begin
                meta[i] <= next_meta[i];
                sync[i] <= next_sync[i];
                prev[i] <= next_prev[i];
            end
            assign pin_io.level[i] = sync[i];
            assign pin_io.rise[i]  = sync[i] & ~prev[i];
        end
    endgenerate
endmodule : spl_pin_sampler

// *** spl_shifter.sv ***
// Eight-stage serial shifter with storage latch and gated parallel drivers.
// Assumes every control pin is slow against the 10 MHz clk and comes from outside its domain.
// Assumes the bench or board holds each pin level for at least two clk periods.
// Outputs lag their pin edges by two to three clk cycles because of the synchronisers.
`timescale 1ns/1ps
`include "spl_params.svh"

// Contract
// (R1) Each shift clock rise loads serial input into stage zero and moves every stage up by one.
// (R2) Each latch clock rise copies all eight shift stages into the storage latch at once.
// (R3) When both clocks rise together the latch takes the shift contents from before that shift.
// (R4) While output enable is low each latch bit is driven onto its parallel output pin.
// (R5) While output enable is high all eight parallel outputs are released to high impedance.
// (R6) Changing output enable never alters the shift stages or the storage latch.
// (R7) Master clear low empties the shift stages and forces serial output low, leaving the latch alone.
// (R8) A latch clock rise during master clear loads all zeros into the latch.
// (R9) Serial output always shows the last stage, which after a shift holds the old stage six.
// (R10) A latch clock rise without a shift clock rise leaves the serial output unchanged.
// (R11) The controller chains devices serial output to serial input on common clocks.
// (R12) The controller sends eight bits highest output first, then pulses the latch clock once.
module spl_shifter (
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              sys_rst,
    // Controller pins
    input  wire logic              serial_in,
    input  wire logic              shift_clk,
    input  wire logic              latch_clk,
    input  wire logic              master_clear_n,
    input  wire logic              output_enable_n,
    // Parallel output pins
    output logic [`SPL_STAGES-1:0] parallel_out,
    output logic [`SPL_STAGES-1:0] parallel_out_oe_n,
    // Cascade pin
    output logic                   serial_cascade_out
);
    spl_pin_if pin_bus ();

    spl_pkg::spl_byte_t shift_stage_bits;
    spl_pkg::spl_byte_t latch_bits;
    spl_pkg::spl_byte_t drive_off;
    spl_pkg::spl_byte_t next_shift;
    spl_pkg::spl_byte_t next_latch;
    spl_pkg::spl_byte_t next_drive_off;

    logic din;
    logic shift_rise;
    logic latch_rise;
    logic clear_n;
    logic oe_n;

    spl_pin_sampler u_sampler (
        .clk     (clk),
        .sys_rst (sys_rst),
        .pins    ({output_enable_n, master_clear_n, latch_clk, shift_clk, serial_in}),
        .pin_io  (pin_bus.sampler)
    );

    assign din        = pin_bus.level[`SPL_PIN_DATA];
    assign shift_rise = pin_bus.rise[`SPL_PIN_SHIFT];
    assign latch_rise = pin_bus.rise[`SPL_PIN_LATCH];
    assign clear_n    = pin_bus.level[`SPL_PIN_CLEAR_N];
    assign oe_n       = pin_bus.level[`SPL_PIN_OE_N];

    // Clear is level sensitive, so it beats any shift edge seen while it is low.
    always_comb begin
        next_shift = shift_stage_bits;
        if (sys_rst || !clear_n) begin
            next_shift = `SPL_BYTE_ZERO; // R7
        end else if (shift_rise) begin
            next_shift = {shift_stage_bits[`SPL_LAST_STAGE-1:0], din}; // R1
        end
    end

    // Each latch bit reads its stage before this cycle's shift lands, which gives the one-pulse lag.
    genvar b;
    generate
        for (b = 0; b < `SPL_STAGES; b++) begin : g_latch
            always_comb begin
                next_latch[b] = latch_bits[b];
                if (sys_rst) begin
                    next_latch[b] = 1'b0;
                end else if (latch_rise && !clear_n) begin
                    next_latch[b] = 1'b0; // R8
                end else if (latch_rise) begin
                    next_latch[b] = shift_stage_bits[b]; // R2 R3
                end
            end
        end
    endgenerate

    // Enable only steers the drivers; it has no path into either register.
    genvar p;
    generate
        for (p = 0; p < `SPL_STAGES; p++) begin : g_drive
            always_comb begin
                next_drive_off[p] = 1'b1;
                if (!sys_rst && !oe_n) begin
                    next_drive_off[p] = 1'b0; // R4
                end else begin
                    next_drive_off[p] = 1'b1; // R5 R6
                end
            end
        end
    endgenerate

    always_ff @(posedge clk) begin
        shift_stage_bits <= next_shift;
        latch_bits       <= next_latch;
        drive_off        <= next_drive_off;
    end

    assign parallel_out       = latch_bits;
    assign parallel_out_oe_n  = drive_off;
    assign serial_cascade_out = shift_stage_bits[`SPL_LAST_STAGE]; // R9 R10

    // Shift edges since the last latch edge, saturating so a long stream cannot wrap back to a byte.
    // It only feeds covers; it keeps them bounded without a goto repetition.
    logic [3:0] shift_seen;
    logic [3:0] next_shift_seen;

    always_comb begin
        next_shift_seen = shift_seen;
        if (sys_rst || latch_rise) begin
            next_shift_seen = 4'h0;
        end else if (shift_rise && clear_n && shift_seen != 4'hf) begin
            next_shift_seen = shift_seen + 4'h1;
        end
    end

    always_ff @(posedge clk) begin
        shift_seen <= next_shift_seen;
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);

    // Register behaviour on pin edges.
    chk_shift_move: assert property (shift_rise && clear_n |=> // R1
        shift_stage_bits == {$past(shift_stage_bits[`SPL_LAST_STAGE-1:0]), $past(din)})
        else $error("Shift stages did not move up on a shift edge.");
    chk_latch_copy: assert property (latch_rise && clear_n |=> latch_bits == $past(shift_stage_bits)) // R2
        else $error("Latch did not copy the shift stages.");
    chk_tied_clocks: assert property (shift_rise && latch_rise && clear_n |=> // R3
        parallel_out == $past(shift_stage_bits) &&
        shift_stage_bits == {$past(shift_stage_bits[`SPL_LAST_STAGE-1:0]), $past(din)})
        else $error("Tied clocks did not leave the latch one pulse behind.");
    chk_latch_hold: assert property (!latch_rise |=> $stable(latch_bits)) // R2
        else $error("Latch moved without a latch edge.");
    chk_shift_hold: assert property (!shift_rise && clear_n |=> $stable(shift_stage_bits)) // R1
        else $error("Shift stages moved without a shift edge.");

    // Each stage must take its lower neighbour's old value, checked stage by stage.
    genvar s;
    generate
        for (s = 1; s < `SPL_STAGES; s++) begin : g_stage_chk
            chk_stage_step: assert property (shift_rise && clear_n |=> // R1
                shift_stage_bits[s] == $past(shift_stage_bits[s-1]))
                else $error("A shift stage did not take its neighbour's value.");
        end
    endgenerate

    // Driver gating.
    chk_drive_on: assert property (!oe_n |=> parallel_out_oe_n == `SPL_BYTE_ZERO) // R4
        else $error("Parallel drivers off while enable is low.");
    chk_drive_off: assert property (oe_n |=> parallel_out_oe_n == `SPL_BYTE_ONES) // R5
        else $error("Parallel drivers on while enable is high.");
    chk_drive_uniform: assert property (parallel_out_oe_n == `SPL_BYTE_ZERO || parallel_out_oe_n == `SPL_BYTE_ONES) // R5
        else $error("Parallel drivers split between on and off.");
    chk_oe_latch: assert property ($changed(oe_n) && !latch_rise |=> $stable(latch_bits)) // R6
        else $error("Enable change disturbed the latch.");
    chk_oe_no_effect: assert property ($changed(oe_n) && !shift_rise && !latch_rise && clear_n |=> // R6
        $stable(shift_stage_bits) && $stable(latch_bits))
        else $error("Enable change disturbed a register.");

    // Clear.
    chk_clear_shift: assert property (!clear_n && !latch_rise |=> // R7
        shift_stage_bits == `SPL_BYTE_ZERO && !serial_cascade_out && $stable(latch_bits))
        else $error("Clear did not empty only the shift stages.");
    chk_latch_zero: assert property (!clear_n && latch_rise |=> parallel_out == `SPL_BYTE_ZERO) // R8
        else $error("Latch edge under clear did not load zeros.");

    // Serial output.
    chk_serial_stage: assert property (shift_rise && clear_n |=> // R9
        serial_cascade_out == $past(shift_stage_bits[`SPL_LAST_STAGE-1]))
        else $error("Serial output is not the old stage six.");
    chk_serial_hold: assert property (latch_rise && !shift_rise && clear_n |=> $stable(serial_cascade_out)) // R10
        else $error("Latch edge alone moved the serial output.");
    chk_latch_alone: assert property (latch_rise && !shift_rise && clear_n |=> $stable(shift_stage_bits)) // R10
        else $error("Latch edge alone moved the shift stages.");
    chk_tied_serial: assert property (shift_rise && latch_rise && clear_n |=> // R9
        serial_cascade_out == $past(shift_stage_bits[`SPL_LAST_STAGE-1]))
        else $error("Tied clocks did not move the serial output.");

    // Reset is the one thing the default disable hides, so this check opts out of it.
    chk_reset_state: assert property (@(posedge clk) disable iff (1'b0) sys_rst |=> // R5
        parallel_out == `SPL_BYTE_ZERO && parallel_out_oe_n == `SPL_BYTE_ONES && !serial_cascade_out)
        else $error("Outputs not at their reset values after a reset edge.");

    cov_full_byte: cover property (shift_seen == 4'h8 && latch_rise);
    cov_chain_spill: cover property (shift_seen == 4'hf);
    cov_tied_edge: cover property (shift_rise && latch_rise && clear_n);
    cov_clear_load: cover property (!clear_n && latch_rise);
    cov_hiz_toggle: cover property (oe_n ##1 !oe_n);
endmodule : spl_shifter

// *** spl_host_model.sv ***
// Host controller model that drives the shifter's data and clock pins.
// Assumes clk runs at 10 MHz; one link period is nine clk cycles, 900 ns.
`timescale 1ns/1ps

module spl_host_model (
    // Clock
    input  wire logic clk,
    // Pins toward the shifter
    output logic      serial_in,
    output logic      shift_clk,
    output logic      latch_clk
);
    initial begin
        serial_in = 1'b0;
        shift_clk = 1'b0;
        latch_clk = 1'b0;
    end

    // Data is inverted once its hold time runs out, so a late sample cannot pass by luck.
    task automatic pulse(input logic sh, input logic la, input logic d);
        serial_in = d;
        repeat (4) @(negedge clk);
        shift_clk = sh;
        latch_clk = la;
        repeat (4) @(negedge clk);
        shift_clk = 1'b0;
        latch_clk = 1'b0;
        serial_in = ~d;
        @(negedge clk);
    endtask : pulse
endmodule : spl_host_model

// *** tb_serial_to_parallel_latched_shifter.sv ***
// Self-checking bench for the latched shifter.
// Assumes the host model drives the data and clock pins.
`timescale 1ns/1ps

module tb_serial_to_parallel_latched_shifter;
    logic               clk = 1'b0;
    logic               sys_rst = 1'b1;
    logic               master_clear_n = 1'b1;
    logic               output_enable_n = 1'b1;
    logic               serial_in, shift_clk, latch_clk, serial_cascade_out;
    spl_pkg::spl_byte_t parallel_out, parallel_out_oe_n, stages, held;
    spl_pkg::spl_byte_t next_dev_out, next_dev_oe_n, chain;
    logic               next_dev_cascade;
    int                 error_cnt = 0;
    int                 comparisons = 0;
    int                 cycles = 0;

    always #50 clk = ~clk;

    spl_host_model host (.clk(clk), .serial_in(serial_in), .shift_clk(shift_clk), .latch_clk(latch_clk));
    spl_shifter dut (.clk(clk), .sys_rst(sys_rst), .serial_in(serial_in), .shift_clk(shift_clk),
        .latch_clk(latch_clk), .master_clear_n(master_clear_n), .output_enable_n(output_enable_n),
        .parallel_out(parallel_out), .parallel_out_oe_n(parallel_out_oe_n),
        .serial_cascade_out(serial_cascade_out));
    spl_shifter dut_chain (.clk(clk), .sys_rst(sys_rst), .serial_in(serial_cascade_out),
        .shift_clk(shift_clk), .latch_clk(latch_clk), .master_clear_n(master_clear_n),
        .output_enable_n(output_enable_n), .parallel_out(next_dev_out),
        .parallel_out_oe_n(next_dev_oe_n), .serial_cascade_out(next_dev_cascade));

    task automatic check(input string name, input spl_pkg::spl_byte_t exp, input spl_pkg::spl_byte_t got);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask : check

    task automatic finish_test;
        $display("errors %0d comparisons %0d", error_cnt, comparisons);
        if (error_cnt == 0 && comparisons > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : finish_test

    // Shifts a byte in highest output first, checking the cascade pin after every edge.
    task automatic test_shift_byte(input spl_pkg::spl_byte_t b);
        for (int i = 7; i >= 0; i--) begin
            host.pulse(1'b1, 1'b0, b[i]);
            chain = {chain[6:0], stages[7]};
            stages = {stages[6:0], b[i]};
            check("cascade", {7'h00, stages[7]}, {7'h00, serial_cascade_out});
        end
    endtask : test_shift_byte

    task automatic test_latch_only;
        held = {7'h00, serial_cascade_out};
        host.pulse(1'b0, 1'b1, 1'b0);
        check("latch", stages, parallel_out);
        check("chain latch", chain, next_dev_out);
        check("cascade kept", held, {7'h00, serial_cascade_out});
        check("drive", 8'h00, parallel_out_oe_n);
    endtask : test_latch_only

    task automatic test_tied_clocks;
        held = stages;
        host.pulse(1'b1, 1'b1, 1'b1);
        chain = {chain[6:0], stages[7]};
        stages = {stages[6:0], 1'b1};
        check("tied latch", held, parallel_out);
        check("tied cascade", {7'h00, stages[7]}, {7'h00, serial_cascade_out});
    endtask : test_tied_clocks

    task automatic test_enable;
        held = parallel_out;
        output_enable_n = 1'b1;
        repeat (6) @(negedge clk);
        check("released", 8'hff, parallel_out_oe_n);
        check("latch kept", held, parallel_out);
        output_enable_n = 1'b0;
        repeat (6) @(negedge clk);
        test_latch_only();
    endtask : test_enable

    task automatic test_clear;
        held = parallel_out;
        master_clear_n = 1'b0;
        repeat (6) @(negedge clk);
        check("clear cascade", 8'h00, {7'h00, serial_cascade_out});
        check("clear latch", held, parallel_out);
        host.pulse(1'b1, 1'b1, 1'b1);
        check("clear load", 8'h00, parallel_out);
        master_clear_n = 1'b1;
        stages = 8'h00;
        chain = 8'h00;
        repeat (6) @(negedge clk);
        test_shift_byte(8'h81);
        test_latch_only();
    endtask : test_clear

    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            error_cnt++;
            finish_test();
        end
    end

    initial begin
        stages = 8'h00;
        chain = 8'h00;
        repeat (4) @(negedge clk);
        sys_rst = 1'b0;
        repeat (5) @(negedge clk);
        check("reset out", 8'h00, parallel_out);
        check("reset enable", 8'hff, parallel_out_oe_n);
        output_enable_n = 1'b0;
        test_shift_byte(8'ha5);
        test_latch_only();
        test_shift_byte(8'h3c);
        test_latch_only();
        test_tied_clocks();
        test_enable();
        test_clear();
        finish_test();
    end
endmodule : tb_serial_to_parallel_latched_shifter
